// [src/pmr_map.svh]
`ifndef PMR_MAP_SVH
`define PMR_MAP_SVH

// array shape
`define PMR_NUM_REGS 20
`define PMR_NUM_CELLS 10
`define PMR_ADDR_W 12

// register offsets (byte addresses)
`define PMR_OFF_TYPE 12'h000
`define PMR_OFF_CLKSEL 12'h004
`define PMR_OFF_POLARITY 12'h008
`define PMR_OFF_REGSTATE 12'h00C
`define PMR_OFF_STATUS 12'h010

// field positions
`define PMR_STATUS_BUSY_BIT 0

// reset values
`define PMR_RST_TYPE 20'h00000
`define PMR_RST_CLKSEL 20'h00000
`define PMR_RST_POLARITY 10'h000

// timing
`define PMR_CLK_PERIOD_NS 8
`define PMR_POWER_UP_RESET_TIME_NS 600
`define PMR_POWER_UP_RESET_TIME_MAX_NS 1000
`define PMR_PUR_CYCLES ((`PMR_POWER_UP_RESET_TIME_NS + `PMR_CLK_PERIOD_NS - 1) / `PMR_CLK_PERIOD_NS)
`define PMR_PUR_CNT_W 7

`endif

// [src/pmr_pkg.sv]
package pmr_pkg;

    typedef logic [19:0] pmr_reg_vec_t;
    typedef logic [9:0] pmr_cell_vec_t;

    typedef enum logic [1:0] {
        PMR_POR_RUN = 2'b01,
        PMR_POR_DONE = 2'b10
    } pmr_por_state_t;

    typedef struct packed {
        pmr_por_state_t st;
        logic [6:0] cnt;
    } pmr_por_t;

    typedef struct packed {
        pmr_reg_vec_t typeT;
        pmr_reg_vec_t clkSelPin;
        pmr_cell_vec_t outInvert;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pmr_slave_t;

    typedef struct packed {
        pmr_reg_vec_t regQ;
        pmr_reg_vec_t clkPrev;
        logic pinPrev;
        pmr_cell_vec_t ioOut;
        pmr_cell_vec_t ioOe;
        pmr_cell_vec_t ioFb;
    } pmr_core_t;

endpackage : pmr_pkg

// [src/pmr_cfg_if.sv]
interface pmr_cfg_if;
    import pmr_pkg::*;
    pmr_reg_vec_t typeT;
    pmr_reg_vec_t clkSelPin;
    pmr_cell_vec_t outInvert;
    pmr_reg_vec_t regState;
    logic purBusy;

    modport cfgSrc (
        output typeT,
        output clkSelPin,
        output outInvert,
        input regState,
        input purBusy
    );

    modport core (
        input typeT,
        input clkSelPin,
        input outInvert,
        output regState,
        output purBusy
    );
endinterface : pmr_cfg_if

// [src/pmr_por_timer.sv]
`include "pmr_map.svh"

module pmr_por_timer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // status
    output logic busy
);
    import pmr_pkg::*;

    pmr_por_t q;
    pmr_por_t d;

    always_comb begin
        d = q;
        case (q.st)
            PMR_POR_RUN: begin
                if (q.cnt == 7'(`PMR_PUR_CYCLES - 1)) begin
                    d.st = PMR_POR_DONE;
                end else begin
                    d.cnt = q.cnt + 7'h01;
                end
            end
            PMR_POR_DONE: begin
                d.st = PMR_POR_DONE;
            end
            default: begin
                d.st = PMR_POR_RUN;
                d.cnt = 7'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= '{st: PMR_POR_RUN, cnt: 7'h00};
        end else begin
            q <= d;
        end
    end

    assign busy = q.st[0];
endmodule : pmr_por_timer

// [src/pmr_apb_slave.sv]
`include "pmr_map.svh"

module pmr_apb_slave (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // configuration to the array
    pmr_cfg_if.cfgSrc cfg
);
    import pmr_pkg::*;

    pmr_slave_t q;
    pmr_slave_t d;
    logic [31:0] rdMux;
    logic hit;

    always_comb begin
        hit = 1'b1;
        rdMux = 32'h00000000;
        case (paddr)
            `PMR_OFF_TYPE: rdMux = {12'h000, q.typeT};
            `PMR_OFF_CLKSEL: rdMux = {12'h000, q.clkSelPin};
            `PMR_OFF_POLARITY: rdMux = {22'h000000, q.outInvert};
            `PMR_OFF_REGSTATE: rdMux = {12'h000, cfg.regState};
            `PMR_OFF_STATUS: rdMux[`PMR_STATUS_BUSY_BIT] = cfg.purBusy;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        d = q;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        d.prdata = 32'h00000000;
        if (psel && penable && !q.pready) begin
            // answer one cycle into the access phase
            d.pready = 1'b1;
            d.pslverr = !hit;
            d.prdata = pwrite ? 32'h00000000 : rdMux;
        end
        if (psel && penable && q.pready && pwrite && !q.pslverr) begin
            // write lands on the completing edge
            case (paddr)
                `PMR_OFF_TYPE: d.typeT = pwdata[19:0];
                `PMR_OFF_CLKSEL: d.clkSelPin = pwdata[19:0];
                `PMR_OFF_POLARITY: d.outInvert = pwdata[9:0];
                default: d.typeT = q.typeT;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= '{typeT: `PMR_RST_TYPE, clkSelPin: `PMR_RST_CLKSEL, outInvert: `PMR_RST_POLARITY,
                   pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000};
        end else begin
            q <= d;
        end
    end

    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign prdata = q.prdata;
    assign cfg.typeT = q.typeT;
    assign cfg.clkSelPin = q.clkSelPin;
    assign cfg.outInvert = q.outInvert;
endmodule : pmr_apb_slave

// [src/pmr_macrocell_array.sv]
`include "pmr_map.svh"

module pmr_macrocell_array (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // array terms
    input wire pmr_pkg::pmr_reg_vec_t sumTerm,
    input wire pmr_pkg::pmr_reg_vec_t resetTerm,
    input wire pmr_pkg::pmr_reg_vec_t clockTerm,
    input wire logic pinClk,
    input wire logic presetTerm,
    input wire pmr_pkg::pmr_cell_vec_t oeTerm,
    // feedback into the array
    output pmr_pkg::pmr_reg_vec_t regFeedback,
    // i/o pins
    input wire pmr_pkg::pmr_cell_vec_t ioIn,
    output pmr_pkg::pmr_cell_vec_t ioOut,
    output pmr_pkg::pmr_cell_vec_t ioOe,
    output pmr_pkg::pmr_cell_vec_t ioInPath
);
    import pmr_pkg::*;

    pmr_cfg_if cfg ();
    pmr_core_t q;
    pmr_core_t d;
    pmr_reg_vec_t edgeHit;
    logic purBusy;

    pmr_apb_slave u_slave (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .cfg(cfg.cfgSrc)
    );

    pmr_por_timer u_por (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .busy(purBusy)
    );

    // per-flop rising edge of the selected clock source
    genvar g;
    generate
        for (g = 0; g < `PMR_NUM_REGS; g++) begin : g_edge
            assign edgeHit[g] = cfg.clkSelPin[g] ? (pinClk && !q.pinPrev) : (clockTerm[g] && !q.clkPrev[g]);
        end
    endgenerate

    always_comb begin
        d = q;
        d.pinPrev = pinClk;
        d.clkPrev = clockTerm;
        for (int i = 0; i < `PMR_NUM_REGS; i++) begin
            if (purBusy) begin
                d.regQ[i] = 1'b0;
            end else if (resetTerm[i]) begin
                // edge history follows the clock, so no edge is pending at release
                d.regQ[i] = 1'b0;
            end else if (edgeHit[i]) begin
                if (presetTerm) begin
                    d.regQ[i] = 1'b1;
                end else if (cfg.typeT[i]) begin
                    d.regQ[i] = q.regQ[i] ^ sumTerm[i];
                end else begin
                    d.regQ[i] = sumTerm[i];
                end
            end
        end
        for (int c = 0; c < `PMR_NUM_CELLS; c++) begin
            // even flop of each cell drives the pin, odd one is buried
            d.ioOut[c] = d.regQ[2 * c] ^ cfg.outInvert[c];
            d.ioOe[c] = oeTerm[c] && !purBusy;
            d.ioFb[c] = ioIn[c];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cfg.regState = q.regQ;
    assign cfg.purBusy = purBusy;
    assign regFeedback = q.regQ;
    assign ioOut = q.ioOut;
    assign ioOe = q.ioOe;
    assign ioInPath = q.ioFb;
endmodule : pmr_macrocell_array

// [tb/pmr_board_model.sv]
module pmr_board_model (
    // clock
    input wire logic ref_clk,
    // request from the bench
    input wire logic go,
    // pin clock to the device
    output logic pinClk
);
    timeunit 1ns;
    timeprecision 1ps;
    // pin clock idles low, one pulse per request only
    always_ff @(posedge ref_clk) begin
        pinClk <= go;
    end
endmodule : pmr_board_model

// [tb/pmr_array_properties.sv]
module pmr_array_properties import pmr_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // array
    input wire pmr_pkg::pmr_reg_vec_t clockTerm,
    input wire pmr_pkg::pmr_reg_vec_t resetTerm,
    input wire logic pinClk,
    input wire logic presetTerm,
    input wire pmr_pkg::pmr_cell_vec_t oeTerm,
    input wire pmr_pkg::pmr_cell_vec_t ioIn,
    input wire pmr_pkg::pmr_reg_vec_t regFeedback,
    input wire pmr_pkg::pmr_cell_vec_t ioOe,
    input wire pmr_pkg::pmr_cell_vec_t ioInPath
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [6:0] cnt;
        pmr_reg_vec_t ckPrev;
        pmr_reg_vec_t rstPrev;
        logic pinPrev;
        logic edgeSeen;
        logic presetHit;
    } pmr_chk_t;
    pmr_chk_t st_q, st_d;
    always_comb begin
        st_d = st_q;
        st_d.cnt = st_q.cnt + {6'h00, st_q.cnt != 7'h7F};
        st_d.ckPrev = clockTerm;
        st_d.rstPrev = resetTerm;
        st_d.pinPrev = pinClk;
        st_d.edgeSeen = |(clockTerm & ~st_q.ckPrev) | (pinClk & !st_q.pinPrev);
        st_d.presetHit = &clockTerm && st_q.ckPrev == '0 && pinClk && !st_q.pinPrev && presetTerm && st_q.cnt > 7'h50;
        if (!nrst) begin
            st_d = '0;
        end
    end
    always_ff @(posedge ref_clk) begin
        st_q <= st_d;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    por_hold_a: assert property (st_q.cnt < 7'h4C |-> regFeedback == '0) else $error("set in power-up");
    por_oe_a: assert property (st_q.cnt < 7'h4C |-> ioOe == '0) else $error("drive in power-up");
    reset_wins_a: assert property ((regFeedback & $past(resetTerm)) == '0) else $error("reset ignored");
    input_path_a: assert property ($past(nrst, 2) |-> ioInPath == $past(ioIn)) else $error("input path");
    oe_follow_a: assert property (st_q.cnt > 7'h50 |-> ioOe == $past(oeTerm)) else $error("enable path");
    hold_idle_a: assert property (!st_q.edgeSeen && st_q.rstPrev == '0 |-> $stable(regFeedback))
        else $error("change without clock");
    preset_all_a: assert property (st_q.presetHit |-> regFeedback == ~st_q.rstPrev) else $error("preset");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("ready late");
    cover property (st_q.presetHit);
    cover property (st_q.rstPrev != '0 && st_q.edgeSeen);
    cover property (st_q.edgeSeen);
endmodule : pmr_array_properties
bind pmr_macrocell_array pmr_array_properties pmr_array_properties_i (.ref_clk(ref_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pready(pready), .clockTerm(clockTerm), .resetTerm(resetTerm),
    .pinClk(pinClk), .presetTerm(presetTerm), .oeTerm(oeTerm), .ioIn(ioIn), .regFeedback(regFeedback),
    .ioOe(ioOe), .ioInPath(ioInPath));

// [tb/pld_macrocell_register_array_tb.sv]
`include "pmr_map.svh"

module pld_macrocell_register_array_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, pinClk, presetTerm, go, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    pmr_pkg::pmr_reg_vec_t sumTerm, resetTerm, clockTerm, regFeedback;
    pmr_pkg::pmr_cell_vec_t oeTerm, ioIn, ioOut, ioOe, ioInPath;
    int mismatches, checks;
    pmr_macrocell_array pmr_macrocell_array_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .sumTerm(sumTerm), .resetTerm(resetTerm),
        .clockTerm(clockTerm), .pinClk(pinClk), .presetTerm(presetTerm), .oeTerm(oeTerm),
        .regFeedback(regFeedback), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .ioInPath(ioInPath));
    pmr_board_model pmr_board_model_i (.ref_clk(ref_clk), .go(go), .pinClk(pinClk));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1 && n++ < 20);
        // no answer within the wait limit counts as a failure
        if (n > 20) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    // pin request leads by one cycle so both clock sources rise together
    task automatic tick(input pmr_pkg::pmr_reg_vec_t ck, input logic pin);
        go <= pin;
        @(posedge ref_clk);
        clockTerm <= ck;
        go <= 1'b0;
        @(posedge ref_clk);
        clockTerm <= 20'h00000;
        repeat (3) @(posedge ref_clk);
    endtask : tick
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        final_report;
    end
    initial begin
        int n;
        {nrst, psel, penable, pwrite, paddr, pwdata, go, presetTerm} = '0;
        {sumTerm, resetTerm, clockTerm, oeTerm, ioIn} = '0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, `PMR_OFF_STATUS, 32'h0);
        chk(rd, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, err}, 32'h1);
        n = 0;
        do apb(1'b0, `PMR_OFF_STATUS, 32'h0); while (rd[0] !== 1'b0 && n++ < 40);
        chk(rd, 32'h0);
        chk({12'h0, regFeedback}, 32'h0);
        $display("test power-up done");
        oeTerm <= 10'h155;
        ioIn <= 10'h2AA;
        apb(1'b1, `PMR_OFF_POLARITY, 32'h3FF);
        // pin drive picks up the new polarity one edge after the write lands
        @(posedge ref_clk);
        chk({22'h0, ioOut}, 32'h3FF);
        chk({22'h0, ioOe}, 32'h155);
        chk({22'h0, ioInPath}, 32'h2AA);
        $display("test pins done");
        sumTerm <= 20'hA5A5A;
        tick(20'hFFFFF, 1'b0);
        chk({12'h0, regFeedback}, 32'hA5A5A);
        apb(1'b1, `PMR_OFF_TYPE, 32'h0F0F0);
        sumTerm <= 20'hFFFFF;
        tick(20'hFFFFF, 1'b0);
        chk({12'h0, regFeedback}, 32'hFAFAF);
        sumTerm <= 20'h00000;
        tick(20'h00003, 1'b0);
        chk({12'h0, regFeedback}, 32'hFAFAC);
        $display("test flop types done");
        apb(1'b1, `PMR_OFF_CLKSEL, 32'h00F00);
        tick(20'h00000, 1'b1);
        chk({12'h0, regFeedback}, 32'hFA0AC);
        tick(20'hFFFFF, 1'b0);
        chk({12'h0, regFeedback}, 32'h0A0A0);
        $display("test clock select done");
        resetTerm <= 20'h00010;
        presetTerm <= 1'b1;
        tick(20'hFFFFF, 1'b1);
        chk({12'h0, regFeedback}, 32'hFFFEF);
        chk({22'h0, ioOut}, 32'h004);
        apb(1'b0, `PMR_OFF_REGSTATE, 32'h0);
        chk(rd, 32'h000FFFEF);
        presetTerm <= 1'b0;
        resetTerm <= 20'hFFFFF;
        repeat (2) @(posedge ref_clk);
        chk({12'h0, regFeedback}, 32'h0);
        resetTerm <= 20'h00000;
        $display("test preset and reset done");
        final_report;
    end
endmodule : pld_macrocell_register_array_tb
